/* File: hw/pmc_map.vh */
// register map, field positions, reset values and timing for power mode control
`ifndef PMC_MAP_VH
`define PMC_MAP_VH
`define PMC_ADDR_W 8
`define PMC_ADDR_PWR_CTRL 8'h87
`define PMC_ADDR_AUX_CTRL 8'h8E
`define PMC_PWR_RESET 8'h00
`define PMC_AUX_RESET 8'h00
`define PMC_BIT_IDLE 0
`define PMC_BIT_PDOWN 1
`define PMC_BIT_GF_LO 2
`define PMC_BIT_GF_HI 3
`define PMC_BIT_COLD 4
`define PMC_BIT_EXIT_TIMED 5
`define PMC_BIT_FE_VIEW 6
`define PMC_BIT_BAUD_DBL 7
`define PMC_AUX_BIT_WDT_IDLE 0
`define PMC_AUX_BIT_LSTB_DIS 1
`define PMC_CLK_MHZ 22'h00_000A
`define PMC_SUT_RC_US0 16'h0010
`define PMC_SUT_RC_US1 16'h0200
`define PMC_SUT_RC_US2 16'h0400
`define PMC_SUT_RC_US3 16'h1000
`define PMC_SUT_XT_US0 16'h0400
`define PMC_SUT_XT_US1 16'h0800
`define PMC_SUT_XT_US2 16'h1000
`define PMC_SUT_XT_US3 16'h4000
`define PMC_INT_RST_CYC 2'h2
`define PMC_CNT_W 18
`endif

/* File: hw/pmc_power_mode_controller.v */
// power mode controller: idle, power-down, wake-up sequencing, control reg
// Functional notes
// - idle bit gates processor clock, state kept
// - port pins hold levels during idle
// - timers and serial keep clocking in idle
// - watchdog idle run selected by control bit
// - supply-dip detector stays on in idle
// - enabled interrupt or reset ends idle
// - hardware clears idle bit on wake
// - power-down stops oscillator, detector, flash
// - hardware clears power-down bit on wake
// - power-down left by reset or interrupt
// - only enabled level-sensitive external irqs wake
// - timed exit: falling edge starts start-up timer
// - start-up length from fuses and clock source
// - external exit: clock held until pin rises
// - reset pin rise restarts with start-up timer
// - early release gives two-cycle internal reset
// - cold-start flag set by power-up, writable
// - baud doubler doubles serial modes 1-3
// - frame-error select picks serial bit seven view
// - strobe disable suppresses address latch strobe
`include "pmc_map.vh"
`timescale 1ns/1ns
`default_nettype none
module pmc_power_mode_controller #(
  parameter [17:0] SUT_DIV = 18'h0_0001
) (
  input wire i_sys_clk,
  input wire i_resetn,
  input wire i_power_up,
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [7:0] o_rdata,
  input wire i_instr_done,
  input wire i_irq_pending,
  input wire i_reset_pin,
  input wire i_ext_irq_zero,
  input wire i_ext_irq_one,
  input wire i_ext_irq_zero_enable,
  input wire i_ext_irq_one_enable,
  input wire i_ext_irq_zero_edge_select,
  input wire i_ext_irq_one_edge_select,
  input wire [1:0] i_startup_time_fuse,
  input wire i_crystal_source,
  input wire [1:0] i_serial_mode,
  input wire i_serial_mode_bit_zero,
  input wire i_frame_error_flag,
  input wire i_ale_raw,
  output wire o_cpu_clk_en,
  output wire o_periph_clk_en,
  output wire o_wdt_clk_en,
  output wire o_port_hold,
  output wire o_osc_en,
  output wire o_flash_pwr_en,
  output wire o_supply_dip_en,
  output wire o_int_reset,
  output wire o_baud_double,
  output wire o_serial_bit7,
  output wire o_ale
);
  // ----------------------------------------
  // reset release
  // ----------------------------------------
  reg rst_s1_r;
  reg rst_s2_r;
  wire rst_n;
  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  assign rst_n = rst_s2_r;

  // ----------------------------------------
  // sequencer states
  // ----------------------------------------
  localparam [2:0] ST_RUN = 3'd0;
  localparam [2:0] ST_IDLE = 3'd1;
  localparam [2:0] ST_PDOWN = 3'd2;
  localparam [2:0] ST_WAKE_TIMED = 3'd3;
  localparam [2:0] ST_WAKE_EXT = 3'd4;
  localparam [2:0] ST_WAKE_RST = 3'd5;
  localparam [2:0] ST_INT_RST = 3'd6;

  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [7:0] pwr_r;
  reg [7:0] pwr_nxt;
  reg [7:0] aux_r;
  reg [17:0] cnt_r;
  reg [17:0] cnt_nxt;
  reg [1:0] irst_r;
  reg [1:0] irst_nxt;
  reg irq0_d_r;
  reg irq1_d_r;
  reg rstpin_d_r;
  reg pend_idle_r;
  reg pend_pd_r;
  reg woke_pin_r;
  reg woke_pin_nxt;

  // ----------------------------------------
  // start-up time select
  // ----------------------------------------
  reg [15:0] sut_us;
  always @* begin
    case ({i_crystal_source, i_startup_time_fuse})
      3'b000: sut_us = `PMC_SUT_RC_US0;
      3'b001: sut_us = `PMC_SUT_RC_US1;
      3'b010: sut_us = `PMC_SUT_RC_US2;
      3'b011: sut_us = `PMC_SUT_RC_US3;
      3'b100: sut_us = `PMC_SUT_XT_US0;
      3'b101: sut_us = `PMC_SUT_XT_US1;
      3'b110: sut_us = `PMC_SUT_XT_US2;
      default: sut_us = `PMC_SUT_XT_US3;
    endcase
  end
  // cycles = us * MHz, divided down only for shortened simulation
  wire [17:0] sut_cyc;
  wire [21:0] sut_full;
  assign sut_full = sut_us * `PMC_CLK_MHZ;
  assign sut_cyc = sut_full[17:0] / SUT_DIV;

  // ----------------------------------------
  // wake qualification
  // ----------------------------------------
  wire wake0_ok;
  wire wake1_ok;
  wire irq_fall;
  wire irq_rise;
  wire rst_rise;
  assign wake0_ok = i_ext_irq_zero_enable & ~i_ext_irq_zero_edge_select;
  assign wake1_ok = i_ext_irq_one_enable & ~i_ext_irq_one_edge_select;
  assign irq_fall = (wake0_ok & irq0_d_r & ~i_ext_irq_zero) |
                    (wake1_ok & irq1_d_r & ~i_ext_irq_one);
  // only a previously low, qualified pin may end an external wake
  assign irq_rise = (wake0_ok & ~irq0_d_r & i_ext_irq_zero) |
                    (wake1_ok & ~irq1_d_r & i_ext_irq_one);
  assign rst_rise = i_reset_pin & ~rstpin_d_r;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always @* begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    irst_nxt = irst_r;
    woke_pin_nxt = woke_pin_r;
    case (state_r)
      ST_RUN: begin
        if (pend_pd_r && i_instr_done) begin
          state_nxt = ST_PDOWN;
        end else if (pend_idle_r && i_instr_done) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (i_irq_pending || i_reset_pin) begin
          state_nxt = ST_RUN;
        end
      end
      ST_PDOWN: begin
        cnt_nxt = 18'h0_0000;
        if (rst_rise) begin
          state_nxt = ST_WAKE_RST;
          woke_pin_nxt = 1'b1;
        end else if (irq_fall) begin
          if (pwr_r[`PMC_BIT_EXIT_TIMED]) begin
            state_nxt = ST_WAKE_TIMED;
          end else begin
            state_nxt = ST_WAKE_EXT;
          end
        end
      end
      ST_WAKE_TIMED: begin
        cnt_nxt = cnt_r + 18'h0_0001;
        if (cnt_r >= sut_cyc) begin
          state_nxt = ST_RUN;
        end
      end
      ST_WAKE_EXT: begin
        if (irq_rise) begin
          state_nxt = ST_RUN;
        end
      end
      ST_WAKE_RST: begin
        if (cnt_r < sut_cyc) begin
          cnt_nxt = cnt_r + 18'h0_0001;
          if (!i_reset_pin) begin
            woke_pin_nxt = 1'b0;
          end
        end else if (!woke_pin_r || !i_reset_pin) begin
          state_nxt = ST_INT_RST;
          irst_nxt = `PMC_INT_RST_CYC;
        end
      end
      ST_INT_RST: begin
        irst_nxt = irst_r - 2'd1;
        if (irst_r == 2'd1) begin
          state_nxt = ST_RUN;
        end
      end
      default: begin
        state_nxt = ST_RUN;
      end
    endcase
  end

  // ----------------------------------------
  // register write and hardware clears
  // ----------------------------------------
  wire wr_pwr;
  wire wr_aux;
  wire wake_idle;
  wire wake_pd;
  assign wr_pwr = i_wr && (i_addr == `PMC_ADDR_PWR_CTRL);
  assign wr_aux = i_wr && (i_addr == `PMC_ADDR_AUX_CTRL);
  assign wake_idle = (state_r == ST_IDLE) && (state_nxt == ST_RUN);
  assign wake_pd = (state_r != ST_RUN) && (state_r != ST_IDLE) &&
                   (state_nxt == ST_RUN);

  always @* begin
    pwr_nxt = pwr_r;
    if (wr_pwr) begin
      pwr_nxt = i_wdata;
    end
    if (wake_idle) begin
      pwr_nxt[`PMC_BIT_IDLE] = 1'b0;
    end
    if (wake_pd) begin
      pwr_nxt[`PMC_BIT_PDOWN] = 1'b0;
    end
    if (i_power_up) begin
      pwr_nxt[`PMC_BIT_COLD] = 1'b1;
    end
  end

  // ----------------------------------------
  // state registers
  // ----------------------------------------
  always @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_RUN;
      cnt_r <= 18'h0_0000;
      irst_r <= 2'd0;
      woke_pin_r <= 1'b0;
      irq0_d_r <= 1'b1;
      irq1_d_r <= 1'b1;
      rstpin_d_r <= 1'b0;
      aux_r <= `PMC_AUX_RESET;
      // cold flag cleared by the reset value; i_power_up or a register write sets it again
      pwr_r <= `PMC_PWR_RESET;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      irst_r <= irst_nxt;
      woke_pin_r <= woke_pin_nxt;
      irq0_d_r <= i_ext_irq_zero;
      irq1_d_r <= i_ext_irq_one;
      rstpin_d_r <= i_reset_pin;
      pwr_r <= pwr_nxt;
      if (wr_aux) begin
        aux_r <= i_wdata;
      end
    end
  end

  // ----------------------------------------
  // pending mode requests
  // ----------------------------------------
  // held until the writing instruction ends, so nothing freezes mid-way
  always @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_idle_r <= 1'b0;
      pend_pd_r <= 1'b0;
    end else begin
      pend_idle_r <= (wr_pwr & i_wdata[`PMC_BIT_IDLE]) |
                     (pend_idle_r & ~i_instr_done);
      pend_pd_r <= (wr_pwr & i_wdata[`PMC_BIT_PDOWN]) |
                   (pend_pd_r & ~i_instr_done);
    end
  end

  // ----------------------------------------
  // register read-back
  // ----------------------------------------
  // data stands one cycle only; zero otherwise
  always @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_rdata <= 8'h00;
    end else if (i_rd && i_addr == `PMC_ADDR_PWR_CTRL) begin
      o_rdata <= pwr_r;
    end else if (i_rd && i_addr == `PMC_ADDR_AUX_CTRL) begin
      o_rdata <= {6'h00, aux_r[1:0]};
    end else begin
      o_rdata <= 8'h00;
    end
  end

  // ----------------------------------------
  // clock gating
  // ----------------------------------------
  wire running;
  wire osc_off;
  assign running = (state_r == ST_RUN) || (state_r == ST_INT_RST);
  assign osc_off = (state_r == ST_PDOWN);
  assign o_cpu_clk_en = running;
  assign o_port_hold = (state_r == ST_IDLE);
  assign o_periph_clk_en = ~osc_off;
  // watchdog runs in idle only when enabled, never in power-down
  assign o_wdt_clk_en = running |
    ((state_r == ST_IDLE) & aux_r[`PMC_AUX_BIT_WDT_IDLE]);

  // ----------------------------------------
  // power switches
  // ----------------------------------------
  assign o_supply_dip_en = ~osc_off;
  assign o_osc_en = ~osc_off;
  assign o_flash_pwr_en = ~osc_off;

  // ----------------------------------------
  // internal reset
  // ----------------------------------------
  // held through the whole reset wake, then two clocked cycles
  assign o_int_reset = (state_r == ST_INT_RST) ||
                       (state_r == ST_WAKE_RST);

  // ----------------------------------------
  // serial and strobe controls
  // ----------------------------------------
  assign o_baud_double = pwr_r[`PMC_BIT_BAUD_DBL] &
                         (i_serial_mode != 2'd0);
  assign o_serial_bit7 = pwr_r[`PMC_BIT_FE_VIEW] ? i_frame_error_flag :
                         i_serial_mode_bit_zero;
  assign o_ale = i_ale_raw & ~aux_r[`PMC_AUX_BIT_LSTB_DIS];
endmodule
`default_nettype wire

/* File: tb/pmc_chk.sv */
// checker: port relations of the power mode controller
`timescale 1ns/1ns
`default_nettype none
module pmc_chk (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_power_up,
  input wire logic i_instr_done,
  input wire logic i_irq_pending,
  input wire logic i_reset_pin,
  input wire logic i_ext_irq_zero,
  input wire logic i_ext_irq_one,
  input wire logic [1:0] i_serial_mode,
  input wire logic i_ale_raw,
  input wire logic o_cpu_clk_en,
  input wire logic o_periph_clk_en,
  input wire logic o_wdt_clk_en,
  input wire logic o_port_hold,
  input wire logic o_osc_en,
  input wire logic o_flash_pwr_en,
  input wire logic o_supply_dip_en,
  input wire logic o_int_reset
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  a_pd_all_off: assert property (
    !o_osc_en |-> !o_cpu_clk_en && !o_flash_pwr_en && !o_supply_dip_en
    && !o_periph_clk_en) else $error("power-down output left on");
  a_idle_outs: assert property (
    o_port_hold |-> !o_cpu_clk_en && o_periph_clk_en && o_supply_dip_en)
    else $error("idle outputs wrong");
  a_wdt_run: assert property (
    o_cpu_clk_en && !o_int_reset |-> o_wdt_clk_en)
    else $error("watchdog clock off while running");
  a_idle_wake: assert property (
    o_port_hold && i_irq_pending |=> !o_port_hold && o_cpu_clk_en)
    else $error("idle not ended by interrupt");
  a_entry_wait: assert property (
    $rose(o_port_hold) || $fell(o_osc_en) |-> $past(i_instr_done))
    else $error("mode entered mid instruction");
  a_pd_stay: assert property (
    !o_osc_en && i_ext_irq_zero && i_ext_irq_one && !i_reset_pin
    && !i_power_up |=> !o_osc_en) else $error("power-down left alone");
  a_int_reset_two: assert property (
    $fell(o_int_reset) |-> $past(o_cpu_clk_en) && $past(o_cpu_clk_en, 2))
    else $error("internal reset not two clocked cycles");
endmodule
bind pmc_power_mode_controller pmc_chk chk (.i_sys_clk, .i_resetn,
  .i_power_up, .i_instr_done, .i_irq_pending, .i_reset_pin,
  .i_ext_irq_zero, .i_ext_irq_one, .i_serial_mode, .i_ale_raw,
  .o_cpu_clk_en, .o_periph_clk_en, .o_wdt_clk_en, .o_port_hold,
  .o_osc_en, .o_flash_pwr_en, .o_supply_dip_en, .o_int_reset);
`default_nettype wire

/* File: tb/pmc_pins.sv */
// partner model: external interrupt pins and reset pin
`timescale 1ns/1ns
`default_nettype none
module pmc_pins (
  input wire logic i_clk,
  output logic o_irq_zero,
  output logic o_irq_one,
  output logic o_rst_pin
);
  // released pins sit at their pull levels
  initial begin
    o_irq_zero = 1'b1;
    o_irq_one = 1'b1;
    o_rst_pin = 1'b0;
  end
  // caller picks n; long n keeps pin low past clock settling
  task irq(input int which, input int n);
    @(posedge i_clk);
    if (which == 0) o_irq_zero <= 1'b0;
    else o_irq_one <= 1'b0;
    repeat (n) @(posedge i_clk);
    o_irq_zero <= 1'b1;
    o_irq_one <= 1'b1;
  endtask
  task rst(input int n);
    @(posedge i_clk);
    o_rst_pin <= 1'b1;
    repeat (n) @(posedge i_clk);
    o_rst_pin <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: tb/pmc_power_mode_controller_bench.sv */
// bench: power mode controller scenarios and verdict
`timescale 1ns/1ns
`default_nettype none
module pmc_power_mode_controller_bench;
  logic i_sys_clk, i_resetn = 1'b0, i_power_up = 1'b0, i_wr = 1'b0;
  logic i_rd = 1'b0, i_instr_done = 1'b0, i_irq_pending = 1'b0;
  logic i_crystal_source = 1'b0, i_ale_raw = 1'b0;
  logic i_ext_irq_zero_enable = 1'b1, i_ext_irq_one_enable = 1'b1;
  logic i_ext_irq_zero_edge_select = 1'b0, i_ext_irq_one_edge_select = 1'b0;
  logic i_serial_mode_bit_zero = 1'b0, i_frame_error_flag = 1'b1;
  logic [1:0] i_startup_time_fuse = 2'b01, i_serial_mode = 2'b01;
  logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, o_rdata, v;
  logic i_reset_pin, i_ext_irq_zero, i_ext_irq_one, o_cpu_clk_en;
  logic o_periph_clk_en, o_wdt_clk_en, o_port_hold, o_osc_en, o_ale;
  logic o_flash_pwr_en, o_supply_dip_en, o_int_reset, o_baud_double;
  logic o_serial_bit7;
  int error_cnt = 0;
  int num_checks = 0;
  int n;
  // 64 shortens start-up: fuse 1 on rc gives 5120/64 = 80 cycles
  pmc_power_mode_controller #(.SUT_DIV(18'h0_0040)) uut (.i_sys_clk,
    .i_resetn, .i_power_up, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_instr_done, .i_irq_pending, .i_reset_pin, .i_ext_irq_zero,
    .i_ext_irq_one, .i_ext_irq_zero_enable, .i_ext_irq_one_enable,
    .i_ext_irq_zero_edge_select, .i_ext_irq_one_edge_select,
    .i_startup_time_fuse, .i_crystal_source, .i_serial_mode,
    .i_serial_mode_bit_zero, .i_frame_error_flag, .i_ale_raw,
    .o_cpu_clk_en, .o_periph_clk_en, .o_wdt_clk_en, .o_port_hold,
    .o_osc_en, .o_flash_pwr_en, .o_supply_dip_en, .o_int_reset,
    .o_baud_double, .o_serial_bit7, .o_ale);
  pmc_pins pins (.i_clk(i_sys_clk), .o_irq_zero(i_ext_irq_zero),
    .o_irq_one(i_ext_irq_one), .o_rst_pin(i_reset_pin));
  task test_done;
    if (error_cnt == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask
  task rd_reg(input logic [7:0] a);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1 v = o_rdata;
  endtask
  // one instruction end after the request write
  task fin;
    @(posedge i_sys_clk);
    i_instr_done <= 1'b1;
    @(posedge i_sys_clk);
    i_instr_done <= 1'b0;
    #1;
  endtask
  task wcpu;
    n = 0;
    while (o_cpu_clk_en !== 1'b1 && n < 4000) begin
      @(posedge i_sys_clk);
      #1 n++;
    end
    if (n == 4000) begin
      chk(16'h0000, 16'h0001);
      test_done;
    end
  endtask
  task t_regs;
    rd_reg(8'h87);
    chk(v, 8'h00);
    wr_reg(8'h87, 8'h0C);
    wr_reg(8'h8E, 8'h03);
    wr_reg(8'h55, 8'hFF);
    i_ale_raw <= 1'b1;
    rd_reg(8'h55);
    chk(v, 8'h00);
    rd_reg(8'h87);
    chk(v, 8'h0C);
    rd_reg(8'h8E);
    chk({v, o_ale}, 9'h006);
    wr_reg(8'h8E, 8'h01);
    rd_reg(8'h8E);
    chk({v, o_ale}, 9'h003);
    i_power_up <= 1'b1;
    @(posedge i_sys_clk);
    i_power_up <= 1'b0;
    rd_reg(8'h87);
    chk(v, 8'h1C);
    wr_reg(8'h87, 8'h00);
    rd_reg(8'h87);
    chk(v, 8'h00);
  endtask
  task t_idle;
    wr_reg(8'h87, 8'h01);
    fin;
    chk({o_cpu_clk_en, o_port_hold, o_wdt_clk_en}, 3'b011);
    @(posedge i_sys_clk);
    i_irq_pending <= 1'b1;
    @(posedge i_sys_clk);
    i_irq_pending <= 1'b0;
    #1 chk(o_cpu_clk_en, 1'b1);
    rd_reg(8'h87);
    chk(v, 8'h00);
  endtask
  task t_timed;
    wr_reg(8'h87, 8'h22);
    fin;
    chk({o_osc_en, o_flash_pwr_en, o_cpu_clk_en}, 3'b000);
    pins.irq(0, 2);
    repeat (3) @(posedge i_sys_clk);
    #1 chk({o_osc_en, o_cpu_clk_en}, 2'b10);
    wcpu;
    chk(n > 60 && n < 90, 1'b1);
    rd_reg(8'h87);
    chk(v, 8'h20);
  endtask
  task t_ext;
    i_ext_irq_zero_edge_select <= 1'b1;
    wr_reg(8'h87, 8'h02);
    fin;
    pins.irq(0, 4);
    #1 chk(o_osc_en, 1'b0);
    fork
      pins.irq(1, 300);
      begin
        repeat (200) @(posedge i_sys_clk);
        #1 chk({o_osc_en, o_cpu_clk_en}, 2'b10);
      end
    join
    wcpu;
    chk(n < 20, 1'b1);
  endtask
  task t_rst;
    wr_reg(8'h87, 8'h02);
    fin;
    pins.rst(3);
    wcpu;
    chk({o_int_reset, o_cpu_clk_en}, 2'b11);
    @(posedge i_sys_clk);
    @(posedge i_sys_clk);
    #1 chk(o_int_reset, 1'b0);
    wr_reg(8'h87, 8'h02);
    fin;
    fork
      pins.rst(150);
      begin
        repeat (120) @(posedge i_sys_clk);
        #1 chk({o_int_reset, o_cpu_clk_en}, 2'b10);
      end
    join
    wcpu;
  endtask
  task t_serial;
    wr_reg(8'h87, 8'hC0);
    rd_reg(8'h87);
    chk({o_baud_double, o_serial_bit7}, 2'b11);
    i_serial_mode <= 2'b00;
    wr_reg(8'h87, 8'h00);
    rd_reg(8'h87);
    chk({o_baud_double, o_serial_bit7}, 2'b00);
  endtask
  initial begin
    i_sys_clk = 1'b0;
    forever #50 i_sys_clk = ~i_sys_clk;
  end
  initial begin
    repeat (12) @(posedge i_sys_clk);
    i_resetn <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    t_regs;
    t_idle;
    t_timed;
    t_ext;
    t_rst;
    t_serial;
    test_done;
  end
endmodule
`default_nettype wire
